/* File: design/arwc_pkg.sv */
package arwc_pkg;

    // Byte offsets of the registers on the bus.
    localparam logic [7:0] CMP0_OFF      = 8'h28;
    localparam logic [7:0] CMP1_OFF      = 8'h2c;
    localparam logic [7:0] FLAG_OFF      = 8'h30;
    localparam logic [7:0] IRQ_STAT_OFF  = 8'h38;
    localparam logic [7:0] IRQ_MASK_OFF  = 8'h3c;
    localparam logic [7:0] FMT_OFF       = 8'h40;

    // Field positions of a compare unit configuration word.
    localparam int THR_LSB   = 16;
    localparam int THR_MSB   = 27;
    localparam int CNT_LSB   = 8;
    localparam int CNT_MSB   = 11;
    localparam int CH_LSB    = 3;
    localparam int CH_MSB    = 5;
    localparam int COND_BIT  = 2;
    localparam int IE_BIT    = 1;
    localparam int EN_BIT    = 0;

    // Writable bits of a configuration word; the rest read as zero.
    localparam logic [31:0] CFG_MASK  = 32'h0fff_0f3f;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // Flag register bit positions.
    localparam int FLAG0_BIT = 1;
    localparam int FLAG1_BIT = 2;

    localparam int RES_W  = 12;
    localparam int CH_W   = 3;
    localparam int MCNT_W = 4;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : arwc_pkg

/* File: design/arwc_top.sv */
// Implementation choice: the AHB-Lite register port.
module arwc_top
(
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic                          res_load,
    input  wire logic [arwc_pkg::CH_W-1:0]     res_ch,
    input  wire logic [arwc_pkg::RES_W-1:0]    res_data,
    output logic                               unit0_match_flag,
    output logic                               unit1_match_flag,
    output logic                               irq
);

    localparam int NUNITS = 2;

    // Field slices below come from the package; refuse a package whose
    // field widths no longer agree with the datapath widths.
    if (arwc_pkg::THR_MSB - arwc_pkg::THR_LSB + 1 != arwc_pkg::RES_W)
    begin : g_bad_thr
        $error("threshold field width differs from result width");
    end

    if (arwc_pkg::CNT_MSB - arwc_pkg::CNT_LSB + 1 != arwc_pkg::MCNT_W)
    begin : g_bad_cnt
        $error("match count field width differs from counter width");
    end

    if (arwc_pkg::CH_MSB - arwc_pkg::CH_LSB + 1 != arwc_pkg::CH_W)
    begin : g_bad_ch
        $error("channel field width differs from channel port width");
    end

    // Both flags share one register, so their bits must not collide.
    if (arwc_pkg::FLAG0_BIT == arwc_pkg::FLAG1_BIT)
    begin : g_bad_flag
        $error("both compare flags sit on the same bit");
    end

    // A write mask that hid a control bit would leave a unit unusable.
    if (!arwc_pkg::CFG_MASK[arwc_pkg::EN_BIT]
        || !arwc_pkg::CFG_MASK[arwc_pkg::IE_BIT]
        || !arwc_pkg::CFG_MASK[arwc_pkg::COND_BIT])
    begin : g_bad_mask
        $error("config write mask hides a control bit");
    end

    // Address phase capture.
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  addr_r;
    logic        take;

    // Register state.
    logic [31:0]       cfg_r [NUNITS];
    logic [NUNITS-1:0] flag_r;
    logic [NUNITS-1:0] irq_stat_r;
    logic [NUNITS-1:0] irq_mask_r;
    logic              result_format_select_r;
    logic [NUNITS-1:0] hit;
    logic [NUNITS-1:0] cfg_wr;
    logic [NUNITS-1:0] flag_clr;
    logic [NUNITS-1:0] rise;
    logic              stat_rd;
    logic [31:0]       rd_val;

    // Only NONSEQ starts a transfer; IDLE and BUSY slots are ignored.
    assign take = hsel && hready && (htrans == arwc_pkg::HTRANS_NONSEQ);

    // The slave never stalls, so every access completes in one data phase.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Latch the address phase for the following data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end
        else
        begin
            wr_pend_r <= take && hwrite;
            rd_pend_r <= take && !hwrite;
            if (take)
                addr_r <= haddr[7:0];
        end
    end

    // Write and status-read decodes act in the data phase, while hwdata stands.
    assign cfg_wr[0] = wr_pend_r && (addr_r == arwc_pkg::CMP0_OFF);
    assign cfg_wr[1] = wr_pend_r && (addr_r == arwc_pkg::CMP1_OFF);
    assign stat_rd   = rd_pend_r && (addr_r == arwc_pkg::IRQ_STAT_OFF);

    // Write-one-to-clear on the flag register.
    always_comb
    begin
        flag_clr = '0;
        if (wr_pend_r && addr_r == arwc_pkg::FLAG_OFF)
        begin
            flag_clr[0] = hwdata[arwc_pkg::FLAG0_BIT];
            flag_clr[1] = hwdata[arwc_pkg::FLAG1_BIT];
        end
    end

    // Per-unit config, unit logic and sticky flag.
    genvar gi;
    generate
        for (gi = 0; gi < NUNITS; gi++)
        begin : g_unit
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    cfg_r[gi] <= arwc_pkg::CFG_RESET;
                else if (cfg_wr[gi])
                    cfg_r[gi] <= hwdata & arwc_pkg::CFG_MASK;
            end

            arwc_unit u_unit
            (
                .hclk       (hclk),
                .hresetn    (hresetn),
                .cfg        (cfg_r[gi]),
                .cfg_wr     (cfg_wr[gi]),
                .signed_fmt (result_format_select_r),
                .res_load   (res_load),
                .res_ch     (res_ch),
                .res_data   (res_data),
                .hit        (hit[gi])
            );

            // A new hit wins over a clear in the same cycle.
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    flag_r[gi] <= 1'b0;
                else if (hit[gi])
                    flag_r[gi] <= 1'b1;
                else if (flag_clr[gi])
                    flag_r[gi] <= 1'b0;
            end

            // Only a fresh flag with its irq enable raises a request.
            assign rise[gi] = hit[gi] && cfg_r[gi][arwc_pkg::IE_BIT];

            // Sticky interrupt status; a read clears it unless set again.
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    irq_stat_r[gi] <= 1'b0;
                else if (rise[gi])
                    irq_stat_r[gi] <= 1'b1;
                else if (stat_rd)
                    irq_stat_r[gi] <= 1'b0;
            end

            // Per-unit register and status checks; both units alike.
            a_cfg_lands: assert property (
                @(posedge hclk) disable iff (!hresetn)
                cfg_wr[gi] |=> cfg_r[gi] ==
                    ($past(hwdata) & arwc_pkg::CFG_MASK))
                else $error("config write did not land");

            a_stat_sets: assert property (
                @(posedge hclk) disable iff (!hresetn)
                rise[gi] |=> irq_stat_r[gi])
                else $error("irq status not set on flag");

            a_stat_clears: assert property (
                @(posedge hclk) disable iff (!hresetn)
                stat_rd && !rise[gi] |=> !irq_stat_r[gi])
                else $error("irq status not cleared by read");

            a_stat_quiet: assert property (
                @(posedge hclk) disable iff (!hresetn)
                !irq_stat_r[gi] && !rise[gi] |=> !irq_stat_r[gi])
                else $error("irq status set without a flag");
        end
    endgenerate

    // Mask and result format registers.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_mask_r             <= '0;
            result_format_select_r <= 1'b0;
        end
        else if (wr_pend_r)
        begin
            if (addr_r == arwc_pkg::IRQ_MASK_OFF)
                irq_mask_r <= hwdata[NUNITS-1:0];
            if (addr_r == arwc_pkg::FMT_OFF)
                result_format_select_r <= hwdata[0];
        end
    end

    // Level interrupt: high while any unmasked status bit is set.
    assign irq              = |(irq_stat_r & irq_mask_r);
    assign unit0_match_flag = flag_r[0];
    assign unit1_match_flag = flag_r[1];

    // Read mux; unmapped offsets read as zero.
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (haddr[7:0])
            arwc_pkg::CMP0_OFF:     rd_val = cfg_r[0];
            arwc_pkg::CMP1_OFF:     rd_val = cfg_r[1];
            arwc_pkg::FLAG_OFF:
            begin
                rd_val[arwc_pkg::FLAG0_BIT] = flag_r[0];
                rd_val[arwc_pkg::FLAG1_BIT] = flag_r[1];
            end
            arwc_pkg::IRQ_STAT_OFF: rd_val[NUNITS-1:0] = irq_stat_r;
            arwc_pkg::IRQ_MASK_OFF: rd_val[NUNITS-1:0] = irq_mask_r;
            arwc_pkg::FMT_OFF:      rd_val[0] = result_format_select_r;
            default:                rd_val = 32'h0000_0000;
        endcase
    end

    // Read data is registered at the address phase edge.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
            hrdata <= rd_val;
    end

    // Register bus checks: writes land and reads return what stood.
    a_mask_lands: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_r && addr_r == arwc_pkg::IRQ_MASK_OFF
        |=> irq_mask_r == $past(hwdata[NUNITS-1:0]))
        else $error("irq mask write did not land");

    a_fmt_lands: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_r && addr_r == arwc_pkg::FMT_OFF
        |=> result_format_select_r == $past(hwdata[0]))
        else $error("format select write did not land");

    a_wr_decode: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_r |-> $past(take && hwrite))
        else $error("write data phase without address phase");

    a_rdata_holds: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");

    a_cfg_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take && !hwrite && haddr[7:0] == arwc_pkg::CMP0_OFF
        |=> hrdata == $past(cfg_r[0]))
        else $error("config read wrong");

    a_flag_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take && !hwrite && haddr[7:0] == arwc_pkg::FLAG_OFF
        |=> hrdata[arwc_pkg::FLAG1_BIT] == $past(flag_r[1])
            && hrdata[arwc_pkg::FLAG0_BIT] == $past(flag_r[0]))
        else $error("flag register read wrong");

    a_stat_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take && !hwrite && haddr[7:0] == arwc_pkg::IRQ_STAT_OFF
        |=> hrdata[NUNITS-1:0] == $past(irq_stat_r))
        else $error("irq status read wrong");

    // Flag and interrupt checks.
    a_flag_sets: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hit[0] |=> unit0_match_flag)
        else $error("unit 0 flag not set on hit");

    a_flag1_sets: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hit[1] |=> unit1_match_flag)
        else $error("unit 1 flag not set on hit");

    a_flag_holds: assert property (
        @(posedge hclk) disable iff (!hresetn)
        flag_r[1] && !flag_clr[1] |=> flag_r[1])
        else $error("unit 1 flag dropped without clear");

    a_flag0_holds: assert property (
        @(posedge hclk) disable iff (!hresetn)
        flag_r[0] && !flag_clr[0] |=> flag_r[0])
        else $error("unit 0 flag dropped without clear");

    a_flag_clears: assert property (
        @(posedge hclk) disable iff (!hresetn)
        flag_clr[0] && !hit[0] |=> !flag_r[0])
        else $error("unit 0 flag not cleared");

    a_flag1_clears: assert property (
        @(posedge hclk) disable iff (!hresetn)
        flag_clr[1] && !hit[1] |=> !flag_r[1])
        else $error("unit 1 flag not cleared");

    a_irq_needs_ie: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(irq_stat_r[0]) |-> $past(cfg_r[0][arwc_pkg::IE_BIT]))
        else $error("irq status without enable");

    a_irq_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rise[1] && irq_mask_r[1]
        && !(wr_pend_r && addr_r == arwc_pkg::IRQ_MASK_OFF) |=> irq)
        else $error("unmasked irq not raised");

    c_hit0: cover property (@(posedge hclk) disable iff (!hresetn)
        hit[0]);
    c_hit1_signed: cover property (@(posedge hclk) disable iff (!hresetn)
        hit[1] && result_format_select_r);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(irq));
    c_clear: cover property (@(posedge hclk) disable iff (!hresetn)
        flag_clr[0] && flag_r[0]);
    c_less_hit: cover property (@(posedge hclk) disable iff (!hresetn)
        hit[1] && !cfg_r[1][arwc_pkg::COND_BIT]);

endmodule : arwc_top

/* File: design/arwc_unit.sv */
// One compare unit: decides on each loaded result and counts matches.
module arwc_unit
(
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic [31:0]                   cfg,
    input  wire logic                          cfg_wr,
    input  wire logic                          signed_fmt,
    input  wire logic                          res_load,
    input  wire logic [arwc_pkg::CH_W-1:0]     res_ch,
    input  wire logic [arwc_pkg::RES_W-1:0]    res_data,
    output logic                               hit
);

    logic [arwc_pkg::RES_W-1:0]  thr;
    logic [arwc_pkg::MCNT_W-1:0] limit;
    logic [arwc_pkg::MCNT_W:0]   cnt_r;
    logic [arwc_pkg::MCNT_W:0]   cnt_nxt;
    logic                        enabled;
    logic                        is_ge;
    logic                        match;

    assign thr     = cfg[arwc_pkg::THR_MSB:arwc_pkg::THR_LSB];
    assign limit   = cfg[arwc_pkg::CNT_MSB:arwc_pkg::CNT_LSB];
    assign enabled = cfg[arwc_pkg::EN_BIT];

    // Flipping the top bits turns a signed compare into an unsigned one.
    always_comb
    begin
        if (signed_fmt)
            is_ge = {~res_data[arwc_pkg::RES_W-1],
                     res_data[arwc_pkg::RES_W-2:0]} >=
                    {~thr[arwc_pkg::RES_W-1],
                     thr[arwc_pkg::RES_W-2:0]};
        else
            is_ge = res_data >= thr;
    end

    // A match needs an enabled unit, the watched channel and the condition.
    assign match = enabled && res_load
        && (res_ch == cfg[arwc_pkg::CH_MSB:arwc_pkg::CH_LSB])
        && (cfg[arwc_pkg::COND_BIT] ? is_ge : !is_ge);

    assign cnt_nxt = cnt_r + {{arwc_pkg::MCNT_W{1'b0}}, 1'b1};
    assign hit     = match && (cnt_nxt == {1'b0, limit} + 5'h01);

    // The counter restarts on disable, reconfiguration or a fired flag.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_r <= '0;
        else if (cfg_wr || !enabled || hit)
            cnt_r <= '0;
        else if (match)
            cnt_r <= cnt_nxt;
    end

    a_cnt_off_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !enabled |=> cnt_r == '0)
        else $error("counter not idle while unit disabled");

    a_cnt_clears: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hit |=> cnt_r == '0)
        else $error("counter not cleared after hit");

    a_cnt_step: assert property (
        @(posedge hclk) disable iff (!hresetn)
        match && !hit && !cfg_wr |=> cnt_r == $past(cnt_r) + 5'h01)
        else $error("counter did not step on match");

endmodule : arwc_unit

/* File: testbench/adc_result_window_compare_test.sv */
// Self-checking bench for the two result compare units.
module adc_result_window_compare_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, res_load;
    logic        unit0_match_flag, unit1_match_flag, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, res_ch;
    logic [11:0] res_data;
    int          failures, checked, cycles;

    arwc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .res_load(res_load),
        .res_ch(res_ch), .res_data(res_data),
        .unit0_match_flag(unit0_match_flag),
        .unit1_match_flag(unit1_match_flag), .irq(irq));
    arwc_result_src i_src (.hclk(hclk), .res_load(res_load),
        .res_ch(res_ch), .res_data(res_data));

    // Free-running bus clock, 100 ns period.
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic stop_test();
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // A hung handshake would otherwise stall the run forever.
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One single-word transfer; waits on hready rather than assuming it.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= arwc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk("register read", e, q);
    endtask : rd

    // Irq, unit1 flag and unit0 flag, once the last edge has settled.
    task automatic flags(input logic [2:0] e);
        #1;
        chk("irq and flags", {29'h0, e}, {29'h0, irq, unit1_match_flag,
            unit0_match_flag});
    endtask : flags

    function automatic logic [31:0] cfg(input logic [11:0] thr,
        input logic [3:0] cnt, input logic [2:0] ch, input logic [2:0] ce);
        return {4'h0, thr, 4'h0, cnt, 2'h0, ch, ce};
    endfunction : cfg

    task automatic t_reset();
        rd(arwc_pkg::CMP0_OFF, 32'h0);
        rd(arwc_pkg::CMP1_OFF, 32'h0);
        rd(8'h00, 32'h0);
        wr(arwc_pkg::CMP1_OFF, 32'hffff_ffff);
        rd(arwc_pkg::CMP1_OFF, 32'h0fff_0f3f);
        chk("hresp", 32'h0, {31'h0, hresp});
        flags(3'h0);
    endtask : t_reset

    task automatic t_count();
        wr(arwc_pkg::FMT_OFF, 32'h0);
        wr(arwc_pkg::CMP1_OFF, 32'h0);
        wr(arwc_pkg::CMP0_OFF, cfg(12'h100, 4'h2, 3'h3, 3'h7));
        i_src.send(3'h3, 12'h100);
        i_src.send(3'h3, 12'h1ff);
        wr(arwc_pkg::CMP0_OFF, cfg(12'h100, 4'h2, 3'h3, 3'h7));
        i_src.send(3'h3, 12'h100);
        i_src.send(3'h3, 12'h200);
        i_src.send(3'h3, 12'h0ff);
        i_src.send(3'h2, 12'hfff);
        flags(3'h0);
        i_src.send(3'h3, 12'h100);
        flags(3'h1);
        rd(arwc_pkg::FLAG_OFF, 32'h2);
        wr(arwc_pkg::IRQ_MASK_OFF, 32'h1);
        flags(3'h5);
        rd(arwc_pkg::IRQ_STAT_OFF, 32'h1);
        flags(3'h1);
        wr(arwc_pkg::FLAG_OFF, 32'h0);
        flags(3'h1);
        wr(arwc_pkg::FLAG_OFF, 32'h2);
        flags(3'h0);
        i_src.send(3'h3, 12'hfff);
        i_src.send(3'h3, 12'hfff);
        flags(3'h0);
    endtask : t_count

    // Same result, unsigned then signed reading against 0x800.
    task automatic t_format();
        wr(arwc_pkg::CMP0_OFF, 32'h0);
        wr(arwc_pkg::CMP1_OFF, cfg(12'h800, 4'h0, 3'h7, 3'h5));
        i_src.send(3'h7, 12'h7ff);
        flags(3'h0);
        wr(arwc_pkg::FMT_OFF, 32'h1);
        i_src.send(3'h7, 12'h7ff);
        flags(3'h2);
        rd(arwc_pkg::IRQ_STAT_OFF, 32'h0);
        wr(arwc_pkg::FLAG_OFF, 32'h4);
        flags(3'h0);
    endtask : t_format

    task automatic t_less();
        wr(arwc_pkg::IRQ_MASK_OFF, 32'h2);
        wr(arwc_pkg::CMP1_OFF, cfg(12'h010, 4'h0, 3'h0, 3'h0));
        i_src.send(3'h0, 12'h00f);
        flags(3'h0);
        wr(arwc_pkg::CMP1_OFF, cfg(12'h010, 4'h0, 3'h0, 3'h3));
        i_src.send(3'h0, 12'h010);
        flags(3'h0);
        i_src.send(3'h0, 12'h00f);
        flags(3'h6);
        rd(arwc_pkg::IRQ_STAT_OFF, 32'h2);
    endtask : t_less

    // Reset for eight cycles, then the scenarios in turn.
    initial
    begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_count();
        t_format();
        t_less();
        stop_test();
    end
endmodule : adc_result_window_compare_test

/* File: testbench/arwc_result_src.sv */
// Stand-in for the conversion path that hands results to the block.
module arwc_result_src
(
    input  wire logic                      hclk,
    output logic                           res_load,
    output logic [arwc_pkg::CH_W-1:0]      res_ch,
    output logic [arwc_pkg::RES_W-1:0]     res_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet lines at time zero, before the first result.
    initial
    begin
        res_load = 1'b0;
        res_ch   = 3'h0;
        res_data = 12'h000;
    end

    // One result with a single-cycle strobe; afterwards the lines show
    // the inverse, so a design that ignores the strobe sees garbage.
    task automatic send(input logic [2:0] ch, input logic [11:0] d);
        @(posedge hclk);
        res_load <= 1'b1;
        res_ch   <= ch;
        res_data <= d;
        @(posedge hclk);
        res_load <= 1'b0;
        res_ch   <= ~ch;
        res_data <= ~d;
    endtask : send
endmodule : arwc_result_src
